// [hw/nvsrs_pkg.sv]
// Functional notes
// - the power-up restore ends within 20 ms of supply rising past trip.
// - host reads and writes are ignored in a store, a restore or low supply.
// - a power-loss or pin store is skipped when nothing new was written.
// - access stays on up to 25 ns after any store, restore or save trigger; here one 50 ns grace cycle, none on power loss.
// - software commands act within 100 us and only while supply is high.
// - a software store locks out host access up to 8 ms, a restore 200 us; here a store adds 500 ns high drive and a 5 us release wait.
// - access is off while the far party drives the store-busy pin low.
// - after the store-busy pin returns high, access is back within 5 us.
// - the pin is driven high for no more than 500 ns before release.
`default_nettype none
package nvsrs_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned RECALL_MS = 20;
  localparam int unsigned STORE_MS = 8;
  localparam int unsigned SW_RECALL_US = 200;
  localparam int unsigned CMD_US = 100;
  localparam int unsigned RELEASE_US = 5;
  localparam int unsigned DELAY_NS = 25;
  localparam int unsigned DRIVE_HIGH_NS = 500;
  localparam int unsigned PULSE_NS = 15;
  // longest times round down, least times round up, never under one cycle
  localparam int unsigned RECALL_CYC = RECALL_MS * (CLK_HZ / 1000);
  localparam int unsigned STORE_CYC = STORE_MS * (CLK_HZ / 1000);
  localparam int unsigned SW_RECALL_CYC = SW_RECALL_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CMD_CYC = CMD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RELEASE_CYC = RELEASE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DELAY_CYC = 1;
  localparam int unsigned DRIVE_HIGH_CYC =
    DRIVE_HIGH_NS / (1_000_000_000 / CLK_HZ);
  localparam int unsigned PULSE_CYC =
    (PULSE_NS + (1_000_000_000 / CLK_HZ) - 1) / (1_000_000_000 / CLK_HZ);
  localparam int unsigned CNT_W = 24;
  typedef enum logic [1:0] {
    NVSRS_CMD_STORE,
    NVSRS_CMD_RECALL,
    NVSRS_CMD_SAVE_ON,
    NVSRS_CMD_SAVE_OFF
  } nvsrs_cmd_e;
  typedef enum {
    NVSRS_ST_POWERUP,
    NVSRS_ST_IDLE,
    NVSRS_ST_GRACE,
    NVSRS_ST_STORE,
    NVSRS_ST_RECALL,
    NVSRS_ST_DRIVE_HIGH,
    NVSRS_ST_PIN_WAIT,
    NVSRS_ST_OFF
  } nvsrs_state_e;
endpackage
`default_nettype wire

// [hw/nvsrs_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module nvsrs_sync (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_async,
  output logic o_level
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic next_level;
  always_comb begin
    next_stage = {stage[1:0], i_async};
    // a change counts once the second and third stages agree
    next_level = (stage[1] == stage[2]) ? stage[2] : o_level;
  end
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      stage <= 3'h7;
      o_level <= 1'h1;
    end else begin
      stage <= next_stage;
      o_level <= next_level;
    end
  end
endmodule // nvsrs_sync
`default_nettype wire

// [hw/nvsrs_sequencer.sv]
`timescale 1ns/10ps
`default_nettype none
module nvsrs_sequencer
  import nvsrs_pkg::*;
#(
  parameter int unsigned RECALL_CYCLES = RECALL_CYC,
  parameter int unsigned STORE_CYCLES = STORE_CYC,
  parameter int unsigned SW_RECALL_CYCLES = SW_RECALL_CYC
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_power_good,
  input wire logic i_store_busy_pin,
  input wire logic i_cmd_valid,
  input wire nvsrs_pkg::nvsrs_cmd_e i_cmd,
  input wire logic i_sram_write,
  output logic o_rw_inhibit,
  output logic o_store_busy_pin_out,
  output logic o_store_busy_pin_oe,
  output logic o_save_enabled,
  output logic o_recall_done
);
  import nvsrs_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic pin_level;
  logic power_level;
  nvsrs_sync u_pin_sync (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_async(i_store_busy_pin),
    .o_level(pin_level)
  );
  nvsrs_sync u_pwr_sync (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_async(i_power_good),
    .o_level(power_level)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  nvsrs_state_e state, next_state;
  nvsrs_state_e after_grace, next_after_grace;
  logic [CNT_W-1:0] count, next_count;
  logic dirty, next_dirty;
  logic save_en, next_save_en;
  logic pending, next_pending;
  nvsrs_cmd_e pend_cmd, next_pend_cmd;
  logic next_inhibit, next_pin_out, next_pin_oe, next_done;
  logic pin_low, power_low;

  // a pin store the device drives itself is not a far-party request
  assign pin_low = !pin_level && !o_store_busy_pin_oe;
  assign power_low = !power_level;

  always_comb begin
    next_state = state;
    next_after_grace = after_grace;
    next_count = count;
    next_save_en = save_en;
    next_pending = pending;
    next_pend_cmd = pend_cmd;
    next_done = o_recall_done;
    // a write in the same cycle as a nonvolatile cycle's start still counts
    next_dirty = dirty;
    if (i_cmd_valid && power_level && !pending) begin
      next_pending = 1'h1;
      next_pend_cmd = i_cmd;
    end
    unique case (state)
      NVSRS_ST_POWERUP: begin
        next_count = count + 1'h1;
        if (power_low) begin
          next_count = '0;
        end else if (count >= CNT_W'(RECALL_CYCLES - 1)) begin
          next_state = NVSRS_ST_IDLE;
          next_dirty = 1'h0;
          next_done = 1'h1;
        end
      end
      NVSRS_ST_IDLE: begin
        next_count = '0;
        if (power_low) begin
          next_after_grace = (save_en && dirty) ? NVSRS_ST_STORE
                                                : NVSRS_ST_OFF;
          next_state = NVSRS_ST_GRACE;
        end else if (pin_low) begin
          next_after_grace = dirty ? NVSRS_ST_STORE
                                   : NVSRS_ST_PIN_WAIT;
          next_state = NVSRS_ST_GRACE;
        end else if (pending) begin
          next_pending = 1'h0;
          unique case (pend_cmd)
            NVSRS_CMD_STORE: next_after_grace = NVSRS_ST_STORE;
            NVSRS_CMD_RECALL: next_after_grace = NVSRS_ST_RECALL;
            NVSRS_CMD_SAVE_ON: begin
              next_save_en = 1'h1;
              next_after_grace = NVSRS_ST_IDLE;
            end
            NVSRS_CMD_SAVE_OFF: begin
              next_save_en = 1'h0;
              next_after_grace = NVSRS_ST_IDLE;
            end
          endcase
          next_state = NVSRS_ST_GRACE;
        end
      end
      NVSRS_ST_GRACE: begin
        next_state = after_grace;
        if (after_grace == NVSRS_ST_STORE ||
            after_grace == NVSRS_ST_RECALL) begin
          next_dirty = 1'h0;
        end
      end
      NVSRS_ST_STORE: begin
        next_count = count + 1'h1;
        if (count >= CNT_W'(STORE_CYCLES - 1)) begin
          next_count = '0;
          next_state = power_low ? NVSRS_ST_OFF : NVSRS_ST_DRIVE_HIGH;
        end
      end
      NVSRS_ST_RECALL: begin
        next_count = count + 1'h1;
        if (count >= CNT_W'(SW_RECALL_CYCLES - 1)) begin
          next_count = '0;
          next_state = NVSRS_ST_IDLE;
        end
      end
      NVSRS_ST_DRIVE_HIGH: begin
        next_count = count + 1'h1;
        if (count >= CNT_W'(DRIVE_HIGH_CYC - 1)) begin
          next_count = '0;
          next_state = NVSRS_ST_PIN_WAIT;
        end
      end
      NVSRS_ST_PIN_WAIT: begin
        // hold off until the far party lets go, then a short settle
        if (pin_low) begin
          next_count = '0;
        end else begin
          next_count = count + 1'h1;
          if (count >= CNT_W'(RELEASE_CYC - 1)) begin
            next_state = NVSRS_ST_IDLE;
          end
        end
      end
      NVSRS_ST_OFF: begin
        next_count = '0;
        next_done = 1'h0;
        if (power_level) begin
          next_state = NVSRS_ST_POWERUP;
        end
      end
    endcase
    if (i_sram_write && !o_rw_inhibit) begin
      next_dirty = 1'h1;
    end
    next_inhibit = !(next_state == NVSRS_ST_IDLE ||
                     next_state == NVSRS_ST_GRACE) || power_low;
    if (next_state == NVSRS_ST_IDLE && pin_low) begin
      next_inhibit = 1'h1;
    end
    next_pin_oe = (next_state == NVSRS_ST_STORE) ||
                  (next_state == NVSRS_ST_DRIVE_HIGH);
    next_pin_out = (next_state == NVSRS_ST_DRIVE_HIGH);
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= NVSRS_ST_POWERUP;
      after_grace <= NVSRS_ST_IDLE;
      count <= '0;
      dirty <= 1'h0;
      save_en <= 1'h1;
      pending <= 1'h0;
      pend_cmd <= NVSRS_CMD_STORE;
      o_rw_inhibit <= 1'h1;
      o_store_busy_pin_out <= 1'h0;
      o_store_busy_pin_oe <= 1'h0;
      o_recall_done <= 1'h0;
      o_save_enabled <= 1'h1;
    end else begin
      state <= next_state;
      after_grace <= next_after_grace;
      count <= next_count;
      dirty <= next_dirty;
      save_en <= next_save_en;
      pending <= next_pending;
      pend_cmd <= next_pend_cmd;
      o_rw_inhibit <= next_inhibit;
      o_store_busy_pin_out <= next_pin_out;
      o_store_busy_pin_oe <= next_pin_oe;
      o_recall_done <= next_done;
      o_save_enabled <= next_save_en;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // a dirty pin request while idle, answered by one grace cycle
  sequence s_pin_request;
    state == NVSRS_ST_IDLE && pin_low && dirty && power_level
    ##1 state == NVSRS_ST_GRACE;
  endsequence

  a_store_pin_low: assert property (
    @(posedge i_clock) disable iff (!i_resetn)
    state == NVSRS_ST_STORE |-> o_store_busy_pin_oe && !o_store_busy_pin_out)
    else $error("pin not driven low during store");
  a_busy_inhibit: assert property (
    @(posedge i_clock) disable iff (!i_resetn)
    (state == NVSRS_ST_STORE || state == NVSRS_ST_RECALL) |-> o_rw_inhibit)
    else $error("host access open during store or restore");
  a_grace_one_cycle: assert property (
    @(posedge i_clock) disable iff (!i_resetn)
    state == NVSRS_ST_GRACE |=> state != NVSRS_ST_GRACE)
    else $error("grace longer than allowed");
  a_pin_store_taken: assert property (
    @(posedge i_clock) disable iff (!i_resetn)
    s_pin_request |=> state == NVSRS_ST_STORE)
    else $error("pin store not started after grace");
  a_skip_clean_store: assert property (
    @(posedge i_clock) disable iff (!i_resetn)
    state == NVSRS_ST_IDLE && !dirty && (power_low || pin_low)
    |=> after_grace != NVSRS_ST_STORE)
    else $error("store started with nothing written");
  a_high_drive_limit: assert property (
    @(posedge i_clock) disable iff (!i_resetn)
    $rose(o_store_busy_pin_out) |-> ##[1:10] !o_store_busy_pin_oe)
    else $error("pin driven high too long");
  // the grace cycle keeps access open one cycle before the lockout
  a_pin_low_blocks: assert property (
    @(posedge i_clock) disable iff (!i_resetn)
    pin_low && state == NVSRS_ST_IDLE |=> ##1 o_rw_inhibit)
    else $error("access open while pin held low");
  a_power_low_blocks: assert property (
    @(posedge i_clock) disable iff (!i_resetn)
    power_low |=> o_rw_inhibit)
    else $error("access open while supply low");
  a_recall_done_open: assert property (
    @(posedge i_clock) disable iff (!i_resetn)
    $rose(o_recall_done) |-> !o_rw_inhibit || pin_low || power_low)
    else $error("power-up restore end did not open access");
  a_cmd_acted: assert property (
    @(posedge i_clock) disable iff (!i_resetn)
    state == NVSRS_ST_IDLE && pending && power_level && !pin_low
    |=> state == NVSRS_ST_GRACE)
    else $error("pending command not acted on");
endmodule // nvsrs_sequencer
`default_nettype wire

// [verif/nvsrs_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module nvsrs_host_model
  import nvsrs_pkg::*;
(
  input wire logic i_clock,
  output logic o_cmd_valid,
  output var nvsrs_pkg::nvsrs_cmd_e o_cmd,
  output logic o_pin_low,
  output logic o_write
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = NVSRS_CMD_SAVE_OFF;
    o_pin_low = 1'b0;
    o_write = 1'b0;
  end
  // ------------------------------------------------------------
  // requests
  // ------------------------------------------------------------
  task automatic send(input nvsrs_cmd_e c);
    @(posedge i_clock);
    o_cmd_valid <= 1'b1;
    o_cmd <= c;
    @(posedge i_clock);
    o_cmd_valid <= 1'b0;
    o_cmd <= nvsrs_cmd_e'(~c);
  endtask
  // whole cycles, well above the shortest accepted request
  task automatic pull(input int n);
    @(posedge i_clock);
    o_pin_low <= 1'b1;
    repeat (n) @(posedge i_clock);
    o_pin_low <= 1'b0;
  endtask
  task automatic write();
    @(posedge i_clock);
    o_write <= 1'b1;
    @(posedge i_clock);
    o_write <= 1'b0;
  endtask
endmodule // nvsrs_host_model
`default_nettype wire

// [verif/nvsrs_sequencer_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module nvsrs_sequencer_bench;
  import nvsrs_pkg::*;
  localparam int RC = 50;
  localparam int SC = 40;
  localparam int RR = 20;
  logic i_clock, i_resetn, power_good;
  logic cmd_valid, pin_low, wr, inh, pin_out, pin_oe, save_en, done;
  logic pin_level;
  nvsrs_cmd_e cmd;
  int err_count, check_count, k;
  // pulled-up pin, low while either party drives low
  assign pin_level = ~((pin_oe & ~pin_out) | pin_low);
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  nvsrs_host_model host (.i_clock(i_clock), .o_cmd_valid(cmd_valid),
    .o_cmd(cmd), .o_pin_low(pin_low), .o_write(wr));
  nvsrs_sequencer #(.RECALL_CYCLES(RC), .STORE_CYCLES(SC),
    .SW_RECALL_CYCLES(RR)) DUT (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_power_good(power_good), .i_store_busy_pin(pin_level),
    .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_sram_write(wr),
    .o_rw_inhibit(inh), .o_store_busy_pin_out(pin_out),
    .o_store_busy_pin_oe(pin_oe), .o_save_enabled(save_en),
    .o_recall_done(done));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic seen, input logic exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: output mismatch", $time);
    end
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return inh;
      1: return pin_oe;
      2: return pin_out;
      3: return done;
      default: return save_en;
    endcase
  endfunction
  // waits on falling edges, counts cycles into k
  task automatic wait_for(input int s, input logic v, input int n);
    for (k = 0; k < n && pick(s) !== v; k++) @(negedge i_clock);
    check_count++;
    if (pick(s) !== v) begin
      err_count++;
      $display("Error at %0t: wait ran out", $time);
      report_and_stop();
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_powerup();
    check(inh, 1'b1);
    wait_for(3, 1'b1, RC + 10);
    wait_for(0, 1'b0, 5);
  endtask
  task automatic t_sw_recall();
    host.send(NVSRS_CMD_RECALL);
    wait_for(0, 1'b1, CMD_CYC);
    wait_for(0, 1'b0, RR + 5);
    check(pin_oe, 1'b0);
  endtask
  task automatic t_sw_store();
    host.send(NVSRS_CMD_STORE);
    wait_for(1, 1'b1, CMD_CYC);
    check(pin_out, 1'b0);
    check(inh, 1'b1);
    wait_for(2, 1'b1, SC + 5);
    check(k >= SC - 2, 1'b1);
    wait_for(1, 1'b0, DRIVE_HIGH_CYC + 1);
    wait_for(0, 1'b0, RELEASE_CYC + 5);
  endtask
  task automatic t_pin(input logic dirty);
    if (dirty) host.write();
    fork
      host.pull(30);
      begin
        repeat (12) @(negedge i_clock);
        check(inh, 1'b1);
        check(pin_oe, dirty);
      end
    join
    if (dirty) wait_for(1, 1'b0, SC + 20);
    wait_for(0, 1'b0, RELEASE_CYC + 8);
  endtask
  task automatic t_power_loss(input nvsrs_cmd_e c, input logic save);
    host.send(c);
    wait_for(4, save, CMD_CYC);
    check(inh, 1'b0);
    host.write();
    @(posedge i_clock);
    power_good <= 1'b0;
    wait_for(0, 1'b1, 10);
    repeat (3) @(negedge i_clock);
    check(pin_oe, save);
    wait_for(1, 1'b0, SC + 20);
    wait_for(3, 1'b0, 5);
    check(inh, 1'b1);
    @(posedge i_clock);
    power_good <= 1'b1;
    t_powerup();
  endtask
  initial begin
    err_count = 0;
    check_count = 0;
    i_resetn = 1'b0;
    power_good = 1'b1;
    repeat (4) @(posedge i_clock);
    i_resetn <= 1'b1;
    t_powerup();
    t_sw_recall();
    t_sw_store();
    t_pin(1'b0);
    t_pin(1'b1);
    t_power_loss(NVSRS_CMD_SAVE_OFF, 1'b0);
    t_power_loss(NVSRS_CMD_SAVE_ON, 1'b1);
    report_and_stop();
  end
endmodule // nvsrs_sequencer_bench
`default_nettype wire
